/* core/dtmf_consts.svh */
// Timing, tone grid and code constants for the dual-tone decoder
`ifndef DTMF_CONSTS_SVH
`define DTMF_CONSTS_SVH

// Clock
`define CLK_HZ              100000000
`define CLK_PERIOD_NS       10

// Low-group and high-group tone grid in Hz
`define LOW_F0              697
`define LOW_F1              770
`define LOW_F2              852
`define LOW_F3              941
`define HIGH_F0             1209
`define HIGH_F1             1336
`define HIGH_F2             1477
`define HIGH_F3             1633

// Period acceptance window around nominal, in parts per thousand
`define TOL_PERMILLE        25
`define PERMILLE            1000

// Averaging score: periods needed before a tone counts as valid
`define AVG_ACCEPT          3'h4
`define AVG_MAX             3'h7

// Longest wait for a tone edge before the tone is declared lost
`define TONE_TIMEOUT_US     1700
`define TONE_TIMEOUT_CYCLES ((`TONE_TIMEOUT_US * 1000) / `CLK_PERIOD_NS)

// Latch settling delay before the delayed strobe rises (least time, rounded up)
`define SETTLE_TIME_NS      4000
`define SETTLE_CYCLES       ((`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Widths and buffering
`define PERIOD_W            18
`define SETTLE_W            10
`define CODE_W              4
`define KEY_FIFO_DEPTH      4

// Code table values that are not simple binary digits
`define CODE_ZERO_SEL0      4'hA
`define CODE_STAR_SEL0      4'hB
`define CODE_HASH_SEL0      4'hC
`define CODE_ZERO_SEL1      4'h0
`define CODE_STAR_SEL1      4'hA
`define CODE_HASH_SEL1      4'hB
`define CODE_LETTER_SEL0    4'hD
`define CODE_LETTER_SEL1    4'hC

`endif

/* core/dtmf_pkg.sv */
// Types shared by the dual-tone decoder files
package dtmf_pkg;

	// Steering sequence states
	typedef enum logic [1:0] {
		STEER_IDLE   = 2'b00,
		STEER_SETTLE = 2'b01,
		STEER_VALID  = 2'b10
	} steer_state_type;

	// Result of matching one measured period against a tone group
	typedef struct packed {
		logic       hit;
		logic [1:0] idx;
	} tone_match_type;

endpackage : dtmf_pkg

/* core/dtmf_steering.sv */
// Dual-tone frequency check, early flag, steering, code latch and key queue
`timescale 1ns/10ps
`include "dtmf_consts.svh"

module dtmf_steering #(
	parameter int CLOCK_HZ            = `CLK_HZ,
	parameter int TONE_TIMEOUT_CYCLES = `TONE_TIMEOUT_CYCLES
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// Limited tone signals from the comparators
	input  wire logic              low_tone_in,
	input  wire logic              high_tone_in,
	// Control inputs
	input  wire logic              table_select,
	input  wire logic              power_down,
	input  wire logic              output_drive_enable,
	// Steering pin: threshold level in, guard drive out
	input  wire logic              steer_in_guard_out_in,
	output      logic              steer_in_guard_out_out,
	output      logic              steer_in_guard_out_oe,
	// Status outputs
	output      logic              early_signal_flag,
	output      logic              guard_time_drive,
	output      logic              delayed_valid_strobe,
	// Three-state code bus
	output      logic              code_out_bit0,
	output      logic              code_out_bit1,
	output      logic              code_out_bit2,
	output      logic              code_out_bit3,
	output      logic              code_out_oe,
	// Queue of registered key codes
	output      logic              key_valid,
	output      logic [`CODE_W-1:0] key_code,
	input  wire logic              key_ready
);

	localparam logic [`PERIOD_W-1:0] TIMEOUT = `PERIOD_W'(TONE_TIMEOUT_CYCLES);
	localparam logic [`SETTLE_W-1:0] SETTLE  = `SETTLE_W'(`SETTLE_CYCLES);

	// Grid frequency of tone k in group g (0 low, 1 high)
	function automatic int tone_freq(input logic grp, input logic [1:0] k);
		int f;
		f = 0;
		case ({grp, k})
			3'b000:  f = `LOW_F0;
			3'b001:  f = `LOW_F1;
			3'b010:  f = `LOW_F2;
			3'b011:  f = `LOW_F3;
			3'b100:  f = `HIGH_F0;
			3'b101:  f = `HIGH_F1;
			3'b110:  f = `HIGH_F2;
			default: f = `HIGH_F3;
		endcase
		return f;
	endfunction : tone_freq

	// Match a measured period against the four grid windows of a group
	function automatic dtmf_pkg::tone_match_type classify(input logic grp,
		input logic [`PERIOD_W-1:0] period);
		dtmf_pkg::tone_match_type m;
		int nom;
		int lo;
		int hi;
		int p;
		m = '0;
		p = int'(period);
		for (int k = 0; k < 4; k++)
		begin
			nom = CLOCK_HZ / tone_freq(grp, 2'(k));
			lo  = (nom * (`PERMILLE - `TOL_PERMILLE)) / `PERMILLE;
			hi  = (nom * (`PERMILLE + `TOL_PERMILLE)) / `PERMILLE;
			if (p >= lo && p <= hi)
			begin
				m.hit = 1'b1;
				m.idx = 2'(k);
			end
		end
		return m;
	endfunction : classify

	// Key code from low row, high column and table select
	function automatic logic [`CODE_W-1:0] key_of(input logic [1:0] row,
		input logic [1:0] col, input logic sel);
		logic [`CODE_W-1:0] c;
		c = 4'h0;
		if (col == 2'h3)
			c = (sel ? `CODE_LETTER_SEL1 : `CODE_LETTER_SEL0) + {2'h0, row};
		else if (row != 2'h3)
			c = 4'(({2'h0, row} * 4'h3) + {2'h0, col} + 4'h1);
		else if (col == 2'h0)
			c = sel ? `CODE_STAR_SEL1 : `CODE_STAR_SEL0;
		else if (col == 2'h1)
			c = sel ? `CODE_ZERO_SEL1 : `CODE_ZERO_SEL0;
		else
			c = sel ? `CODE_HASH_SEL1 : `CODE_HASH_SEL0;
		return c;
	endfunction : key_of

	dtmf_pkg::steer_state_type state;
	dtmf_pkg::steer_state_type next_state;

	logic                run;
	logic [1:0]          tone_in;
	logic [1:0]          tone_valid;
	logic [1:0]          tone_idx [2];
	logic                steer_meta;
	logic                steer_high;
	logic [`SETTLE_W-1:0] settle_cnt;
	logic [`CODE_W-1:0]  code_latch;
	logic                pair_now;
	logic                do_register;
	logic                fifo_in_ready;
	logic [`CODE_W-1:0]  new_code;

	// Tone, steering and status logic runs only while not powered down; the code bus and key queue always clock
	assign run     = ~power_down;
	assign tone_in = {high_tone_in, low_tone_in};

	// Period measurement and averaging for each tone group
	for (genvar g = 0; g < 2; g++)
	begin : group
		logic                 prev;
		logic [`PERIOD_W-1:0] period_cnt;
		logic [1:0]           idx;
		logic [2:0]           score;
		logic                 edge_seen;
		logic                 timed_out;
		dtmf_pkg::tone_match_type match;

		assign edge_seen = tone_in[g] & ~prev;
		assign timed_out = (period_cnt >= TIMEOUT);
		assign match     = classify(1'(g), period_cnt);

		// Score rises on repeated matches of one tone, falls on misses
		always_ff @(posedge clk)
		begin
			if (!rst_n)
			begin
				prev       <= 1'b0;
				period_cnt <= '0;
				idx        <= 2'h0;
				score      <= 3'h0;
			end
			else if (run)
			begin
				prev <= tone_in[g];
				if (timed_out)
				begin
					score      <= 3'h0;
					period_cnt <= '0;
				end
				else if (edge_seen)
				begin
					period_cnt <= `PERIOD_W'(1);
					if (match.hit && match.idx == idx && score != `AVG_MAX)
						score <= score + 3'h1;
					else if (match.hit && score == 3'h0)
					begin
						idx   <= match.idx;
						score <= 3'h1;
					end
					else if (!(match.hit && match.idx == idx) && score != 3'h0)
						score <= score - 3'h1;
				end
				else
					period_cnt <= period_cnt + `PERIOD_W'(1);
			end
		end

		assign tone_valid[g] = (score >= `AVG_ACCEPT);
		assign tone_idx[g]   = idx;
	end

	// Both groups valid at once is the signal condition
	assign pair_now    = tone_valid[0] & tone_valid[1];
	assign new_code    = key_of(tone_idx[0], tone_idx[1], table_select);
	// Register only on steering above threshold with the flag still up and queue space
	assign do_register = (state == dtmf_pkg::STEER_IDLE) & steer_high &
		early_signal_flag & fifo_in_ready;

	// Steering sequence; a low steering level always returns to idle
	always_comb
	begin
		next_state = state;
		case (state)
			dtmf_pkg::STEER_IDLE:
			begin
				if (do_register)
					next_state = dtmf_pkg::STEER_SETTLE;
			end
			dtmf_pkg::STEER_SETTLE:
			begin
				if (!steer_high)
					next_state = dtmf_pkg::STEER_IDLE;
				else if (settle_cnt == `SETTLE_W'(1))
					next_state = dtmf_pkg::STEER_VALID;
			end
			dtmf_pkg::STEER_VALID:
			begin
				if (!steer_high)
					next_state = dtmf_pkg::STEER_IDLE;
			end
			default: next_state = dtmf_pkg::STEER_IDLE;
		endcase
	end

	// Steering level synchroniser
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			steer_meta <= 1'b0;
			steer_high <= 1'b0;
		end
		else if (run)
		begin
			steer_meta <= steer_in_guard_out_in;
			steer_high <= steer_meta;
		end
	end

	// State, settle timer and code latch
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state      <= dtmf_pkg::STEER_IDLE;
			settle_cnt <= '0;
			code_latch <= 4'h0;
		end
		else if (run)
		begin
			state <= next_state;
			if (do_register)
			begin
				code_latch <= new_code;
				settle_cnt <= SETTLE;
			end
			else if (settle_cnt != '0)
				settle_cnt <= settle_cnt - `SETTLE_W'(1);
		end
	end

	// Status and steering pin outputs
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			early_signal_flag      <= 1'b0;
			guard_time_drive       <= 1'b0;
			delayed_valid_strobe   <= 1'b0;
			steer_in_guard_out_out <= 1'b0;
			steer_in_guard_out_oe  <= 1'b0;
		end
		else if (run)
		begin
			early_signal_flag      <= pair_now;
			guard_time_drive       <= (next_state != dtmf_pkg::STEER_IDLE) & pair_now;
			delayed_valid_strobe   <= (next_state == dtmf_pkg::STEER_VALID);
			steer_in_guard_out_out <= pair_now;
			steer_in_guard_out_oe  <= 1'b1;
		end
	end

	// Code bus: data from the latch, enable follows the drive enable input
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			code_out_bit0 <= 1'b0;
			code_out_bit1 <= 1'b0;
			code_out_bit2 <= 1'b0;
			code_out_bit3 <= 1'b0;
			code_out_oe   <= 1'b0;
		end
		else
		begin
			code_out_bit0 <= code_latch[0];
			code_out_bit1 <= code_latch[1];
			code_out_bit2 <= code_latch[2];
			code_out_bit3 <= code_latch[3];
			code_out_oe   <= output_drive_enable;
		end
	end

	// Queue of registered codes; a full queue holds off registration
	key_fifo #(
		.WIDTH (`CODE_W),
		.DEPTH (`KEY_FIFO_DEPTH)
	) key_queue (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (do_register),
		.in_data   (new_code),
		.in_ready  (fifo_in_ready),
		.out_valid (key_valid),
		.out_data  (key_code),
		.out_ready (key_ready)
	);

endmodule : dtmf_steering

/* core/key_fifo.sv */
// Shift-register FIFO with registered head entry and valid/ready on both sides
`timescale 1ns/10ps

module key_fifo #(
	parameter int WIDTH = 4,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Fill side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output      logic             in_ready,
	// Drain side
	output      logic             out_valid,
	output      logic [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);

	logic [WIDTH-1:0] mem      [DEPTH];
	logic [WIDTH-1:0] next_mem [DEPTH];
	logic [DEPTH-1:0] vld;
	logic [DEPTH-1:0] next_vld;
	logic             push;
	logic             pop;

	// Handshakes; full is the last slot occupied
	assign in_ready  = ~vld[DEPTH-1];
	assign out_valid = vld[0];
	assign out_data  = mem[0];
	assign push      = in_valid & in_ready;
	assign pop       = vld[0] & out_ready;

	// Shift down on pop, then write the first free slot on push
	always_comb
	begin
		logic [DEPTH-1:0] sh_vld;
		sh_vld = '0;
		for (int i = 0; i < DEPTH; i++)
		begin
			if (pop && i < DEPTH - 1)
			begin
				sh_vld[i]   = vld[i+1];
				next_mem[i] = mem[i+1];
			end
			else if (pop)
			begin
				sh_vld[i]   = 1'b0;
				next_mem[i] = mem[i];
			end
			else
			begin
				sh_vld[i]   = vld[i];
				next_mem[i] = mem[i];
			end
		end
		next_vld = sh_vld;
		for (int i = 0; i < DEPTH; i++)
		begin
			if (push && !sh_vld[i] && (i == 0 || sh_vld[(i == 0) ? 0 : i-1]))
			begin
				next_vld[i] = 1'b1;
				next_mem[i] = in_data;
			end
		end
	end

	// Storage update
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			vld <= '0;
		else
			vld <= next_vld;
		for (int i = 0; i < DEPTH; i++)
			mem[i] <= next_mem[i];
	end

endmodule : key_fifo

/* verif/dtmf_steering_monitor.sv */
// Port checker for the dual-tone steering block
`timescale 1ns/10ps
`include "dtmf_consts.svh"

module dtmf_steering_monitor #(
	parameter int CLOCK_HZ            = `CLK_HZ,
	parameter int TONE_TIMEOUT_CYCLES = `TONE_TIMEOUT_CYCLES
) (
	// Clock and reset
	input wire logic               clk,
	input wire logic               rst_n,
	// Inputs
	input wire logic               low_tone_in,
	input wire logic               high_tone_in,
	input wire logic               table_select,
	input wire logic               power_down,
	input wire logic               output_drive_enable,
	input wire logic               steer_in_guard_out_in,
	input wire logic               key_ready,
	// Outputs
	input wire logic               steer_in_guard_out_out,
	input wire logic               steer_in_guard_out_oe,
	input wire logic               early_signal_flag,
	input wire logic               guard_time_drive,
	input wire logic               delayed_valid_strobe,
	input wire logic               code_out_bit0,
	input wire logic               code_out_bit1,
	input wire logic               code_out_bit2,
	input wire logic               code_out_bit3,
	input wire logic               code_out_oe,
	input wire logic               key_valid,
	input wire logic [`CODE_W-1:0] key_code
);
	logic [9:0] since_guard;

	default clocking dc @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Cycles since the guard drive last rose, saturating
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			since_guard <= 10'h000;
		else if ($rose(guard_time_drive))
			since_guard <= 10'h001;
		else if (since_guard != 10'h3FF)
			since_guard <= since_guard + 10'h001;
	end

	// Strobe rises one settling delay after registration
	property p_settle;
		$rose(delayed_valid_strobe) |-> since_guard == 10'(`SETTLE_CYCLES);
	endproperty
	a_settle: assert property (p_settle)
		else $error("strobe rose off the settling delay");

	// Registration only while the early flag was high
	property p_register;
		$rose(guard_time_drive) |-> $past(early_signal_flag, 2);
	endproperty
	a_register: assert property (p_register)
		else $error("registration without early flag");

	// Guard drive ends with the early flag
	property p_guard_drop;
		$fell(early_signal_flag) |-> ##[0:1] !guard_time_drive;
	endproperty
	a_guard_drop: assert property (p_guard_drop)
		else $error("guard drive outlived the early flag");

	// Strobe released three cycles after steering falls
	property p_release;
		$fell(steer_in_guard_out_in) |-> ##3 !delayed_valid_strobe;
	endproperty
	a_release: assert property (p_release)
		else $error("strobe not released");

	// Latch changes only just after a registration
	property p_hold;
		!$stable({code_out_bit3, code_out_bit2, code_out_bit1, code_out_bit0})
			|-> $past(guard_time_drive) && !$past(guard_time_drive, 2);
	endproperty
	a_hold: assert property (p_hold)
		else $error("code latch changed without registration");

	// Bus drive follows the enable one cycle later
	property p_enable;
		$past(rst_n) |-> code_out_oe == $past(output_drive_enable);
	endproperty
	a_enable: assert property (p_enable)
		else $error("code bus drive does not follow enable");

	// Early flag and strobe hold while powered down
	property p_freeze;
		$past(power_down) && $past(power_down, 2)
			|-> $stable(early_signal_flag) && $stable(delayed_valid_strobe);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state changed in power-down");

	// Steering pin drive mirrors the early flag
	property p_pin;
		steer_in_guard_out_oe |-> steer_in_guard_out_out == early_signal_flag;
	endproperty
	a_pin: assert property (p_pin)
		else $error("steering pin drive wrong");
endmodule : dtmf_steering_monitor

/* verif/far_side_model.sv */
// Steering RC network and key-reading host at the decoder's far side
`timescale 1ns/10ps

module far_side_model #(
	parameter int GUARD = 300
) (
	// Clock
	input  wire logic clk,
	// Steering pin
	input  wire logic pin_out,
	input  wire logic pin_oe,
	output      logic steer_level,
	// Key queue
	input  wire logic stall,
	output      logic key_ready
);
	int charge = 0;

	initial
	begin
		steer_level = 1'b0;
		key_ready = 1'b0;
	end

	// Capacitor charges while the pin drives high; threshold only after a full guard span
	always @(posedge clk)
	begin
		#1;
		charge = (pin_oe && pin_out) ? charge + (charge < GUARD) : charge - (charge > 0);
		steer_level = charge == GUARD ? 1'b1 : charge == 0 ? 1'b0 : steer_level;
		key_ready = !stall;
	end
endmodule : far_side_model

/* verif/tb.sv */
// Self-checking bench for the dual-tone steering block
`timescale 1ns/10ps
`include "dtmf_consts.svh"

module tb;
	localparam int CHZ = 100000;
	int lf[4] = '{`LOW_F0, `LOW_F1, `LOW_F2, `LOW_F3};
	int hf[4] = '{`HIGH_F0, `HIGH_F1, `HIGH_F2, `HIGH_F3};
	int lp = 0, hp = 0, lc = 0, hc = 0, errors = 0, comparisons = 0;
	logic clk = 1'b0, rst_n = 1'b0, low_tone_in = 1'b0, high_tone_in = 1'b0;
	logic table_select = 1'b0, power_down = 1'b0, output_drive_enable = 1'b1;
	logic stall = 1'b1, seen_f = 1'b0, seen_s = 1'b0;
	logic steer, pin_out, pin_oe, flag, guard, strobe, c0, c1, c2, c3;
	logic code_oe, key_valid, key_ready;
	logic [3:0] key_code;
	logic [3:0] exp_q[$];
	wire  [3:0] code = {c3, c2, c1, c0};

	always #5 clk = ~clk;

	// Square-wave tones of whole-cycle periods; zero period is silence
	always @(posedge clk) #1
	begin
		lc = (lp == 0 || lc >= lp - 1) ? 0 : lc + 1;
		hc = (hp == 0 || hc >= hp - 1) ? 0 : hc + 1;
		low_tone_in = lp != 0 && lc < lp / 2;
		high_tone_in = hp != 0 && hc < hp / 2;
	end

	dtmf_steering #(.CLOCK_HZ(CHZ), .TONE_TIMEOUT_CYCLES(200)) dut (
		.clk(clk), .rst_n(rst_n), .low_tone_in(low_tone_in), .high_tone_in(high_tone_in),
		.table_select(table_select), .power_down(power_down),
		.output_drive_enable(output_drive_enable), .steer_in_guard_out_in(steer),
		.steer_in_guard_out_out(pin_out), .steer_in_guard_out_oe(pin_oe),
		.early_signal_flag(flag), .guard_time_drive(guard), .delayed_valid_strobe(strobe),
		.code_out_bit0(c0), .code_out_bit1(c1), .code_out_bit2(c2), .code_out_bit3(c3),
		.code_out_oe(code_oe), .key_valid(key_valid), .key_code(key_code),
		.key_ready(key_ready)
	);

	far_side_model #(.GUARD(300)) host (
		.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .steer_level(steer),
		.stall(stall), .key_ready(key_ready)
	);

	task automatic check(logic [3:0] seen, logic [3:0] want, string what);
		comparisons++;
		if (seen !== want)
		begin
			errors++;
			$display("wrong value at %0t: %s saw %h expected %h", $time, what, seen, want);
		end
	endtask : check

	task automatic report_and_stop;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop

	// Expected code for a low row and high column under either table
	function automatic logic [3:0] code_of(int r, int c, logic s);
		if (c == 3)
			return 4'(r) + (s ? 4'hC : 4'hD);
		if (r < 3)
			return 4'(3 * r + c + 1);
		return c == 0 ? (s ? 4'hA : 4'hB) : c == 1 ? (s ? 4'h0 : 4'hA) : (s ? 4'hB : 4'hC);
	endfunction : code_of

	// Lets cycles pass, noting whether flag or strobe were seen
	task automatic run(int n);
		repeat (n)
		begin
			@(posedge clk);
			#1;
			seen_f |= flag;
			seen_s |= strobe;
		end
	endtask : run

	// One key: tones until the strobe, then silence until it is released
	task automatic press(int r, int c, logic s);
		logic [3:0] want;
		want = code_of(r, c, s);
		table_select = s;
		lp = CHZ / lf[r];
		hp = CHZ / hf[c];
		exp_q.push_back(want);
		for (int i = 0; i < 3000 && strobe !== 1'b1; i++) run(1);
		check(4'(strobe), 4'h1, "strobe");
		check(4'(guard), 4'h1, "guard drive");
		check(code, want, "latched code");
		lp = 0;
		hp = 0;
		for (int i = 0; i < 3000 && strobe !== 1'b0; i++) run(1);
		check(code, want, "held code");
		check(4'(flag), 4'h0, "flag after tone");
	endtask : press

	// Every popped key matches the next key pressed
	always @(posedge clk)
		if (rst_n && key_valid === 1'b1 && key_ready === 1'b1)
			check(key_code, exp_q.pop_front(), "queued key");

	initial
	begin
		repeat (10) @(posedge clk);
		#1 rst_n = 1'b1;
		run(2);
		check(code, 4'h0, "code after reset");
		check(4'(pin_oe), 4'h1, "steering pin driven");
		output_drive_enable = 1'b0;
		run(2);
		check(4'(code_oe), 4'h0, "bus released");
		output_drive_enable = 1'b1;
		// Burst too short for the guard span
		lp = CHZ / lf[0];
		hp = CHZ / hf[0];
		run(600);
		check(4'(code_oe), 4'h1, "bus driven");
		lp = 0;
		hp = 0;
		run(600);
		check(4'(seen_f), 4'h1, "burst flag");
		check(4'(seen_s), 4'h0, "burst ignored");
		// Tones under power-down
		seen_f = 1'b0;
		power_down = 1'b1;
		lp = CHZ / lf[2];
		hp = CHZ / hf[2];
		run(800);
		lp = 0;
		hp = 0;
		check(4'(seen_f), 4'h0, "frozen flag");
		power_down = 1'b0;
		run(300);
		// All sixteen keys in both tables; host stalls until the queue refuses
		for (int s = 0; s < 2; s++)
			for (int k = 0; k < 16; k++)
			begin
				if (s == 0 && k == 4)
					fork
						begin
							run(1500);
							check(4'(strobe), 4'h0, "full queue refuses");
							stall = 1'b0;
						end
					join_none
				press(k % 4, k / 4, s[0]);
			end
		run(20);
		check(4'(key_valid), 4'h0, "queue drained");
		check(4'(exp_q.size()), 4'h0, "all keys popped");
		report_and_stop();
	end

	// Cuts a hung run short
	initial
	begin
		repeat (100000) @(posedge clk);
		errors++;
		report_and_stop();
	end
endmodule : tb

bind dtmf_steering dtmf_steering_monitor #(
	.CLOCK_HZ(CLOCK_HZ),
	.TONE_TIMEOUT_CYCLES(TONE_TIMEOUT_CYCLES)
) mon (
	.clk(clk), .rst_n(rst_n), .low_tone_in(low_tone_in), .high_tone_in(high_tone_in),
	.table_select(table_select), .power_down(power_down),
	.output_drive_enable(output_drive_enable), .steer_in_guard_out_in(steer_in_guard_out_in),
	.key_ready(key_ready), .steer_in_guard_out_out(steer_in_guard_out_out),
	.steer_in_guard_out_oe(steer_in_guard_out_oe), .early_signal_flag(early_signal_flag),
	.guard_time_drive(guard_time_drive), .delayed_valid_strobe(delayed_valid_strobe),
	.code_out_bit0(code_out_bit0), .code_out_bit1(code_out_bit1),
	.code_out_bit2(code_out_bit2), .code_out_bit3(code_out_bit3),
	.code_out_oe(code_out_oe), .key_valid(key_valid), .key_code(key_code)
);
